// ==== rtl/piamp_regs.sv ====
// Purpose: per-port access-list table control, mirroring and ingress priority registers
// Assumes: AXI4-Lite slave, 32-bit data, registers in the low byte of each word
// Notes: frame events and priority candidates come from switch logic on this clock
//
// Added by the designer: the AXI4-Lite interface to the registers.
`default_nettype none

module piamp_regs #(
  parameter int NUM_PORTS = piamp_pkg::NUM_PORTS
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [piamp_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [piamp_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire piamp_pkg::piamp_frame_evt_t [NUM_PORTS-1:0] FRAME_EVT,
  input wire piamp_pkg::piamp_prio_cand_t [NUM_PORTS-1:0] PRIO_CAND,
  output logic [NUM_PORTS-1:0] MON_MARK,
  output logic [NUM_PORTS-1:0][NUM_PORTS-1:0] MON_FWD_MAP,
  output logic [NUM_PORTS-1:0] SNIFFER_EN,
  output logic [NUM_PORTS-1:0][piamp_pkg::PRIO_W-1:0] PRIO_OUT
);
  import piamp_pkg::*;

  localparam logic [2:0] PORT_LIMIT = 3'(NUM_PORTS);

  // bus write side
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [7:0] w_byte_q, w_byte_d;
  logic w_lane0_q, w_lane0_d;
  logic [1:0] bresp_q, bresp_d;
  logic wr_fire;
  piamp_dec_t wdec;

  // bus read side
  logic rvalid_q, rvalid_d;
  logic [7:0] rbyte_q, rbyte_d;
  logic [1:0] rresp_q, rresp_d;
  piamp_dec_t rdec;

  // per-port registers and table operation
  logic [NUM_PORTS-1:0][127:0] acl_data_q, acl_data_d;
  logic [NUM_PORTS-1:0][15:0] be_q, be_d;
  logic [NUM_PORTS-1:0][4:0] ctl_q, ctl_d;
  logic [NUM_PORTS-1:0] wr_done_q, wr_done_d, rd_done_q, rd_done_d;
  logic [NUM_PORTS-1:0][7:0] mirror_q, mirror_d, prio_ctl_q, prio_ctl_d;
  piamp_op_state_t [NUM_PORTS-1:0] op_state_q, op_state_d;
  logic [NUM_PORTS-1:0] op_wr_q, op_wr_d;
  logic [NUM_PORTS-1:0][3:0] op_idx_q, op_idx_d;
  logic [NUM_PORTS-1:0] start, mem_we, mem_re;
  logic [NUM_PORTS-1:0][127:0] mem_rdata;

  // frame-side outputs
  logic [NUM_PORTS-1:0] mark_q, mark_d, sniffer_vec;
  logic [NUM_PORTS-1:0][NUM_PORTS-1:0] fwd_q, fwd_d;
  logic [NUM_PORTS-1:0][PRIO_W-1:0] prio_q, prio_d;

  function automatic logic [PRIO_W-1:0] resolve(input logic [7:0] ctl, input piamp_prio_cand_t c);
    logic [4:0][PRIO_W-1:0] v;
    logic [4:0] en;
    logic [PRIO_W-1:0] r;
    logic found;
    // precedence for single selection: acl, mac, vlan, 802.1p, diffserv
    v = {c.acl, c.mac, c.vlan, c.pcp, c.dscp};
    en[4] = ctl[PRIO_ACL_BIT];
    en[3] = ctl[PRIO_MAC_BIT];
    en[2] = ctl[PRIO_VLAN_BIT];
    en[1] = ctl[PRIO_PCP_BIT];
    en[0] = ctl[PRIO_DSCP_BIT];
    r = '0;
    found = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      if (en[i]) begin
        if (ctl[PRIO_HIGHEST_BIT]) begin
          r = (v[i] > r) ? v[i] : r;
        end else if (ctl[PRIO_OR_BIT]) begin
          r = r | v[i];
        end else if (!found) begin
          r = v[i];
        end
        found = 1'b1;
      end
    end
    return found ? r : c.dflt;
  endfunction

  assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY = !w_have_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_byte_d = w_byte_q;
    w_lane0_d = w_lane0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    wdec = piamp_decode(aw_addr_q, PORT_LIMIT);
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_d = 1'b1;
      aw_addr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_d = 1'b1;
      w_byte_d = S_AXI_WDATA[7:0];
      w_lane0_d = S_AXI_WSTRB[0];
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wdec.hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_byte_q <= w_byte_d;
      w_lane0_q <= w_lane0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  always_comb begin
    acl_data_d = acl_data_q;
    be_d = be_q;
    ctl_d = ctl_q;
    wr_done_d = wr_done_q;
    rd_done_d = rd_done_q;
    mirror_d = mirror_q;
    prio_ctl_d = prio_ctl_q;
    op_state_d = op_state_q;
    op_wr_d = op_wr_q;
    op_idx_d = op_idx_q;
    start = '0;
    mem_we = '0;
    mem_re = '0;
    if (wr_fire && wdec.hit && w_lane0_q) begin
      case (wdec.kind)
        K_DATA: acl_data_d[wdec.port][{wdec.lane, 3'b000} +: 8] = w_byte_q;
        K_BE_MSB: be_d[wdec.port][15:8] = w_byte_q;
        K_BE_LSB: begin
          be_d[wdec.port][7:0] = w_byte_q;
          start[wdec.port] = 1'b1;
        end
        K_CTRL: ctl_d[wdec.port] = w_byte_q[4:0];
        K_MIRROR: mirror_d[wdec.port] = w_byte_q & MIRROR_WMASK;
        K_PRIO: prio_ctl_d[wdec.port] = w_byte_q & PRIO_WMASK;
        default: ;
      endcase
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      case (op_state_q[p])
        OP_IDLE: begin
          if (start[p]) begin
            op_wr_d[p] = ctl_q[p][CTRL_DIR_BIT];
            op_idx_d[p] = ctl_q[p][3:0];
            wr_done_d[p] = !ctl_q[p][CTRL_DIR_BIT] && wr_done_q[p];
            rd_done_d[p] = ctl_q[p][CTRL_DIR_BIT] && rd_done_q[p];
            op_state_d[p] = OP_ACCESS;
          end
        end
        OP_ACCESS: begin
          mem_we[p] = op_wr_q[p];
          mem_re[p] = !op_wr_q[p];
          op_state_d[p] = OP_LOAD;
        end
        OP_LOAD: begin
          if (op_wr_q[p]) begin
            wr_done_d[p] = 1'b1;
          end else begin
            for (int b = 0; b < ACL_BYTES; b++) begin
              if (be_q[p][b]) begin
                acl_data_d[p][8*b +: 8] = mem_rdata[p][8*b +: 8];
              end
            end
            rd_done_d[p] = 1'b1;
          end
          op_state_d[p] = OP_IDLE;
        end
        default: op_state_d[p] = OP_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      acl_data_q <= {NUM_PORTS{DATA_RST}};
      be_q <= {NUM_PORTS{BE_RST}};
      ctl_q <= {NUM_PORTS{CTRL_RST}};
      wr_done_q <= {NUM_PORTS{DONE_RST}};
      rd_done_q <= {NUM_PORTS{DONE_RST}};
      mirror_q <= {NUM_PORTS{MIRROR_RST}};
      prio_ctl_q <= {NUM_PORTS{PRIO_RST}};
      for (int p = 0; p < NUM_PORTS; p++) begin
        op_state_q[p] <= OP_IDLE;
      end
      op_wr_q <= '0;
      op_idx_q <= '0;
    end else begin
      acl_data_q <= acl_data_d;
      be_q <= be_d;
      ctl_q <= ctl_d;
      wr_done_q <= wr_done_d;
      rd_done_q <= rd_done_d;
      mirror_q <= mirror_d;
      prio_ctl_q <= prio_ctl_d;
      op_state_q <= op_state_d;
      op_wr_q <= op_wr_d;
      op_idx_q <= op_idx_d;
    end
  end

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_table
    piamp_table_mem #(
      .DEPTH(ACL_ENTRIES),
      .BYTES(ACL_BYTES),
      .AW(4)
    ) u_mem (
      .clk(CLOCK),
      .rst_n(RST_N),
      .we(mem_we[g]),
      .re(mem_re[g]),
      .addr(op_idx_q[g]),
      .be(be_q[g]),
      .wdata(acl_data_q[g]),
      .rdata(mem_rdata[g])
    );
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rbyte_d = rbyte_q;
    rresp_d = rresp_q;
    rdec = piamp_decode(S_AXI_ARADDR, PORT_LIMIT);
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d = rdec.hit ? RESP_OKAY : RESP_SLVERR;
      rbyte_d = 8'h00;
      if (rdec.hit) begin
        case (rdec.kind)
          K_DATA: rbyte_d = acl_data_q[rdec.port][{rdec.lane, 3'b000} +: 8];
          K_BE_MSB: rbyte_d = be_q[rdec.port][15:8];
          K_BE_LSB: rbyte_d = be_q[rdec.port][7:0];
          // status flags with bit 7 zero
          K_CTRL: rbyte_d = {1'b0, wr_done_q[rdec.port], rd_done_q[rdec.port], ctl_q[rdec.port]};
          K_MIRROR: rbyte_d = mirror_q[rdec.port];
          K_PRIO: rbyte_d = prio_ctl_q[rdec.port];
          default: rbyte_d = 8'h00;
        endcase
      end
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
      rbyte_q <= 8'h00;
      rresp_q <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rbyte_q <= rbyte_d;
      rresp_q <= rresp_d;
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      sniffer_vec[p] = mirror_q[p][MIR_SNIFFER_BIT];
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      mark_d[p] = (FRAME_EVT[p].rx && mirror_q[p][MIR_RX_BIT]) || (FRAME_EVT[p].tx && mirror_q[p][MIR_TX_BIT]);
      // copy goes to the sniffer ports
      fwd_d[p] = mark_d[p] ? sniffer_vec : '0;
      prio_d[p] = resolve(prio_ctl_q[p], PRIO_CAND[p]);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      mark_q <= '0;
      fwd_q <= '0;
      prio_q <= '0;
    end else begin
      mark_q <= mark_d;
      fwd_q <= fwd_d;
      prio_q <= prio_d;
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = {24'h000000, rbyte_q};
  assign MON_MARK = mark_q;
  assign MON_FWD_MAP = fwd_q;
  assign SNIFFER_EN = sniffer_vec;
  assign PRIO_OUT = prio_q;

endmodule // piamp_regs

`default_nettype wire

// ==== rtl/piamp_pkg.sv ====
// Purpose: constants and types for the per-port ingress, mirror and priority registers
// Assumes: one clock, synchronous active-low reset, 32-bit AXI4-Lite register access
// Notes: register index = (port << 12) | offset; byte address = 4 * index
// What this block does
// - write done flag in bit 6, resets 1
// - read done flag in bit 5, resets 1
// - low byte-enable write starts enabled-byte transfer
// - receive sniff marks and copies received frames
// - transmit sniff marks and copies transmitted frames
// - sniffer bit makes port the mirror destination
// - bit 7 picks highest available priority
// - bit 6 ORs all available priorities when bit 7 is clear
// - bit 4 enables MAC address classification
// - bit 3 enables VLAN classification
// - bit 2 enables 802.1p classification
// - bit 1 enables Diffserv classification
// - bit 0 enables access-list classification
`default_nettype none

package piamp_pkg;

  localparam int NUM_PORTS = 6;
  localparam int ACL_ENTRIES = 16;
  localparam int ACL_BYTES = 16;
  localparam int ADDR_W = 17;
  localparam int PRIO_W = 3;

  localparam logic [11:0] OFS_ACL_DATA = 12'h600;
  localparam logic [11:0] OFS_BE_MSB = 12'h610;
  localparam logic [11:0] OFS_BE_LSB = 12'h611;
  localparam logic [11:0] OFS_ACL_CTRL = 12'h612;
  localparam logic [11:0] OFS_MIRROR = 12'h800;
  localparam logic [11:0] OFS_PRIO = 12'h801;

  localparam int CTRL_WR_DONE_BIT = 6;
  localparam int CTRL_RD_DONE_BIT = 5;
  localparam int CTRL_DIR_BIT = 4;
  localparam int MIR_RX_BIT = 6;
  localparam int MIR_TX_BIT = 5;
  localparam int MIR_SNIFFER_BIT = 1;
  localparam int PRIO_HIGHEST_BIT = 7;
  localparam int PRIO_OR_BIT = 6;
  localparam int PRIO_MAC_BIT = 4;
  localparam int PRIO_VLAN_BIT = 3;
  localparam int PRIO_PCP_BIT = 2;
  localparam int PRIO_DSCP_BIT = 1;
  localparam int PRIO_ACL_BIT = 0;

  localparam logic [7:0] CTRL_WMASK = 8'h1f;
  localparam logic [7:0] MIRROR_WMASK = 8'h62;
  localparam logic [7:0] PRIO_WMASK = 8'hdf;

  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic DONE_RST = 1'b1;
  localparam logic [7:0] MIRROR_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [15:0] BE_RST = 16'h0000;
  localparam logic [127:0] DATA_RST = 128'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_DATA = 3'b001,
    K_BE_MSB = 3'b010,
    K_BE_LSB = 3'b011,
    K_CTRL = 3'b100,
    K_MIRROR = 3'b101,
    K_PRIO = 3'b110
  } piamp_kind_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_ACCESS = 2'b01,
    OP_LOAD = 2'b10
  } piamp_op_state_t;

  typedef struct packed {
    logic hit;
    logic [2:0] port;
    piamp_kind_t kind;
    logic [3:0] lane;
  } piamp_dec_t;

  typedef struct packed {
    logic rx;
    logic tx;
  } piamp_frame_evt_t;

  typedef struct packed {
    logic [PRIO_W-1:0] mac;
    logic [PRIO_W-1:0] vlan;
    logic [PRIO_W-1:0] pcp;
    logic [PRIO_W-1:0] dscp;
    logic [PRIO_W-1:0] acl;
    logic [PRIO_W-1:0] dflt;
  } piamp_prio_cand_t;

  // byte k of the table data sits in lane 15-k, matching the byte-enable order
  function automatic piamp_dec_t piamp_decode(input logic [ADDR_W-1:0] addr, input logic [2:0] nports);
    logic [14:0] idx;
    logic [11:0] ofs;
    piamp_dec_t d;
    idx = addr[ADDR_W-1:2];
    ofs = idx[11:0];
    d = '0;
    d.port = idx[14:12] - 3'd1;
    d.lane = ~ofs[3:0];
    if (ofs[11:4] == OFS_ACL_DATA[11:4]) begin
      d.kind = K_DATA;
    end else if (ofs == OFS_BE_MSB) begin
      d.kind = K_BE_MSB;
    end else if (ofs == OFS_BE_LSB) begin
      d.kind = K_BE_LSB;
    end else if (ofs == OFS_ACL_CTRL) begin
      d.kind = K_CTRL;
    end else if (ofs == OFS_MIRROR) begin
      d.kind = K_MIRROR;
    end else if (ofs == OFS_PRIO) begin
      d.kind = K_PRIO;
    end else begin
      d.kind = K_NONE;
    end
    d.hit = (idx[14:12] != 3'd0) && (idx[14:12] <= nports) && (d.kind != K_NONE);
    return d;
  endfunction

endpackage : piamp_pkg

`default_nettype wire

// ==== rtl/piamp_table_mem.sv ====
// Purpose: one port's access-list table, byte-writable, registered read
// Assumes: single clock, synchronous active-low reset on the read register only
// Notes: write and read are never asked for in the same cycle by the owner
`default_nettype none

module piamp_table_mem #(
  parameter int DEPTH = 16,
  parameter int BYTES = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [BYTES-1:0] be,
  input wire logic [8*BYTES-1:0] wdata,
  output logic [8*BYTES-1:0] rdata
);

  logic [8*BYTES-1:0] mem [DEPTH];
  logic [8*BYTES-1:0] rdata_q;
  logic [8*BYTES-1:0] rdata_d;

  always_comb begin
    rdata_d = re ? mem[addr] : rdata_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // only enabled lanes change
  always_ff @(posedge clk) begin
    for (int b = 0; b < BYTES; b++) begin
      if (we && be[b]) begin
        mem[addr][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
  end

  assign rdata = rdata_q;

endmodule // piamp_table_mem

`default_nettype wire

// ==== verification/piamp_regs_chk.sv ====
// Purpose: port-level checks of piamp_regs
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every piamp_regs instance
`default_nettype none
module piamp_regs_chk #(
  parameter int NUM_PORTS = 6
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire piamp_pkg::piamp_frame_evt_t [NUM_PORTS-1:0] FRAME_EVT,
  input wire piamp_pkg::piamp_prio_cand_t [NUM_PORTS-1:0] PRIO_CAND,
  input wire logic [NUM_PORTS-1:0] MON_MARK,
  input wire logic [NUM_PORTS-1:0][NUM_PORTS-1:0] MON_FWD_MAP,
  input wire logic [NUM_PORTS-1:0] SNIFFER_EN,
  input wire logic [NUM_PORTS-1:0][piamp_pkg::PRIO_W-1:0] PRIO_OUT
);
  import piamp_pkg::*;
  logic run_q;
  // checks rest for the edge at which reset lets go
  always_ff @(posedge CLOCK) begin
    run_q <= RST_N;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N || !run_q);
  chk_b_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID)
    else $error("no write response");
  chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("no read response");
  chk_rdata_high: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [PRIO_W-1:0] any_c;
    logic same_c;
    assign any_c = PRIO_CAND[p].mac | PRIO_CAND[p].vlan | PRIO_CAND[p].pcp | PRIO_CAND[p].dscp
      | PRIO_CAND[p].acl | PRIO_CAND[p].dflt;
    assign same_c = (PRIO_CAND[p] == {6{PRIO_CAND[p].dflt}});
    chk_mark_cause: assert property (MON_MARK[p] |-> $past(FRAME_EVT[p].rx || FRAME_EVT[p].tx))
      else $error("monitor mark without frame");
    chk_map_sniffer: assert property (MON_MARK[p] |-> MON_FWD_MAP[p] == $past(SNIFFER_EN))
      else $error("forward map differs from sniffers");
    chk_map_idle: assert property (!MON_MARK[p] |-> MON_FWD_MAP[p] == '0)
      else $error("forward map without mark");
    chk_prio_same: assert property (same_c |=> PRIO_OUT[p] == $past(PRIO_CAND[p].dflt))
      else $error("priority not taken from candidates");
    chk_prio_bits: assert property ((PRIO_OUT[p] & ~$past(any_c)) == '0)
      else $error("priority bit from no candidate");
  end
endmodule // piamp_regs_chk
bind piamp_regs piamp_regs_chk #(.NUM_PORTS(NUM_PORTS)) piamp_regs_chk_i (
  .CLOCK(CLOCK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .FRAME_EVT(FRAME_EVT), .PRIO_CAND(PRIO_CAND), .MON_MARK(MON_MARK), .MON_FWD_MAP(MON_FWD_MAP),
  .SNIFFER_EN(SNIFFER_EN), .PRIO_OUT(PRIO_OUT)
);
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: self-checking bench of piamp_regs
// Assumes: 50 MHz clock, synchronous active-low reset
// Notes: register rows first, then table, mirror, strobe and reset cases
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import piamp_pkg::*;
  localparam int NP = 6;
  typedef struct {
    logic [2:0] pt;
    logic [11:0] o;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
    logic [1:0] rs;
    logic [2:0] ep;
  } piamp_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] aw_addr = '0;
  logic [ADDR_W-1:0] ar_addr = '0;
  logic [31:0] w_data = '0;
  logic [3:0] w_strb = 4'h1;
  logic [3:0] sb = 4'h1;
  logic aw_valid = 1'b0;
  logic w_valid = 1'b0;
  logic b_ready = 1'b0;
  logic ar_valid = 1'b0;
  logic r_ready = 1'b0;
  piamp_frame_evt_t [NP-1:0] evt = '0;
  piamp_prio_cand_t [NP-1:0] cand = {NP{3'h1, 3'h2, 3'h4, 3'h6, 3'h3, 3'h5}};
  logic aw_rdy, w_rdy, b_valid, ar_rdy, r_valid;
  logic [1:0] b_resp, r_resp, wrsp, rrsp;
  logic [31:0] r_data, rdv;
  logic [NP-1:0] mon_mark, sniffer_en;
  logic [NP-1:0][NP-1:0] mon_map;
  logic [NP-1:0][PRIO_W-1:0] prio_out;
  int mismatches = 0;
  int compares = 0;
  piamp_row_t rows [20] = '{
    '{3'h1, 12'h612, 1'h0, 8'h00, 8'h60, 2'h0, 3'h0}, '{3'h1, 12'h800, 1'h0, 8'h00, 8'h00, 2'h0, 3'h0},
    '{3'h1, 12'h801, 1'h0, 8'h00, 8'h00, 2'h0, 3'h5}, '{3'h1, 12'h612, 1'h1, 8'hff, 8'h7f, 2'h0, 3'h0},
    '{3'h1, 12'h612, 1'h1, 8'h00, 8'h60, 2'h0, 3'h0}, '{3'h1, 12'h800, 1'h1, 8'hff, 8'h62, 2'h0, 3'h0},
    '{3'h2, 12'h800, 1'h0, 8'h00, 8'h00, 2'h0, 3'h0}, '{3'h1, 12'h800, 1'h1, 8'h00, 8'h00, 2'h0, 3'h0},
    '{3'h6, 12'h612, 1'h1, 8'h05, 8'h65, 2'h0, 3'h0}, '{3'h1, 12'h801, 1'h1, 8'hff, 8'hdf, 2'h0, 3'h6},
    '{3'h1, 12'h801, 1'h1, 8'h10, 8'h10, 2'h0, 3'h1}, '{3'h1, 12'h801, 1'h1, 8'h08, 8'h08, 2'h0, 3'h2},
    '{3'h1, 12'h801, 1'h1, 8'h04, 8'h04, 2'h0, 3'h4}, '{3'h1, 12'h801, 1'h1, 8'h02, 8'h02, 2'h0, 3'h6},
    '{3'h1, 12'h801, 1'h1, 8'h01, 8'h01, 2'h0, 3'h3}, '{3'h1, 12'h801, 1'h1, 8'h8c, 8'h8c, 2'h0, 3'h4},
    '{3'h1, 12'h801, 1'h1, 8'h58, 8'h58, 2'h0, 3'h3}, '{3'h1, 12'h700, 1'h1, 8'h55, 8'h00, 2'h2, 3'h0},
    '{3'h7, 12'h800, 1'h1, 8'hff, 8'h00, 2'h2, 3'h0}, '{3'h1, 12'h801, 1'h1, 8'h00, 8'h00, 2'h0, 3'h5}};

  piamp_regs #(.NUM_PORTS(NP)) piamp_regs_i (
    .CLOCK(clk), .RST_N(rst_n), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_rdy),
    .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_rdy),
    .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
    .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
    .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .FRAME_EVT(evt), .PRIO_CAND(cand), .MON_MARK(mon_mark),
    .MON_FWD_MAP(mon_map), .SNIFFER_EN(sniffer_en), .PRIO_OUT(prio_out)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] pt, input logic [11:0] o, input logic [7:0] d);
    int n;
    @(posedge clk);
    aw_addr <= {pt, o, 2'b00};
    w_data <= {24'h0, d};
    w_strb <= sb;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (aw_rdy === 1'b1) aw_valid <= 1'b0;
      if (w_rdy === 1'b1) w_valid <= 1'b0;
      if (b_valid === 1'b1 && b_ready === 1'b1) break;
      // response waits one edge before bready rises
      if (b_valid === 1'b1) b_ready <= 1'b1;
    end
    wrsp = b_resp;
    b_ready <= 1'b0;
    if (n == 40) mismatches++;
  endtask

  task automatic rd(input logic [2:0] pt, input logic [11:0] o);
    int n;
    @(posedge clk);
    ar_addr <= {pt, o, 2'b00};
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (ar_rdy === 1'b1) ar_valid <= 1'b0;
      if (r_valid === 1'b1) break;
    end
    rdv = r_data;
    rrsp = r_resp;
    r_ready <= 1'b0;
    if (n == 40) mismatches++;
  endtask

  task automatic poll(input int b);
    for (int n = 0; n < 20; n++) begin
      rd(3'h1, OFS_ACL_CTRL);
      if (rdv[b] === 1'b1) break;
    end
    chk(32'(rdv[b]), 32'h1);
  endtask

  // start an operation and catch its done flag low
  task automatic op(input logic [7:0] be, input int b);
    fork
      wr(3'h1, OFS_BE_LSB, be);
      begin
        repeat (2) @(posedge clk);
        rd(3'h1, OFS_ACL_CTRL);
      end
    join
    chk(32'(rdv[b]), 32'h0);
    poll(b);
  endtask

  task automatic frame(input int p, input logic [1:0] ev, input logic m);
    @(posedge clk);
    evt[p] <= ev;
    @(posedge clk);
    evt[p] <= 2'b00;
    #1;
    chk(32'(mon_mark[p]), 32'(m));
    chk(32'(mon_map[p]), m ? 32'h4 : 32'h0);
  endtask

  task automatic conclude();
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    forever #10 clk = ~clk;
  end

  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].pt, rows[i].o, rows[i].d);
        chk(32'(wrsp), 32'(rows[i].rs));
      end
      rd(rows[i].pt, rows[i].o);
      chk(rdv, 32'(rows[i].e));
      chk(32'(rrsp), 32'(rows[i].rs));
      if (rows[i].o == OFS_PRIO && rows[i].pt == 3'h1) begin
        chk(32'(prio_out[0]), 32'(rows[i].ep));
      end
    end
    wr(3'h1, OFS_ACL_CTRL, 8'h13);
    for (int i = 0; i < 16; i++) wr(3'h1, OFS_ACL_DATA + 12'(i), 8'h10 + 8'(i));
    wr(3'h1, OFS_BE_MSB, 8'hff);
    op(8'h0f, CTRL_WR_DONE_BIT);
    wr(3'h1, OFS_ACL_DATA, 8'h00);
    wr(3'h1, OFS_ACL_DATA + 12'hf, 8'h00);
    wr(3'h1, OFS_ACL_CTRL, 8'h03);
    wr(3'h1, OFS_BE_MSB, 8'h80);
    op(8'h00, CTRL_RD_DONE_BIT);
    rd(3'h1, OFS_ACL_DATA);
    chk(rdv, 32'h10);
    rd(3'h1, OFS_ACL_DATA + 12'hf);
    chk(rdv, 32'h0);
    wr(3'h1, OFS_BE_MSB, 8'h00);
    op(8'h01, CTRL_RD_DONE_BIT);
    rd(3'h1, OFS_ACL_DATA + 12'hf);
    chk(rdv, 32'h1f);
    wr(3'h1, OFS_MIRROR, 8'h40);
    wr(3'h2, OFS_MIRROR, 8'h20);
    wr(3'h3, OFS_MIRROR, 8'h02);
    chk(32'(sniffer_en), 32'h4);
    frame(0, 2'b10, 1'b1);
    frame(0, 2'b01, 1'b0);
    frame(1, 2'b01, 1'b1);
    frame(1, 2'b10, 1'b0);
    frame(2, 2'b11, 1'b0);
    // empty strobe leaves the register alone
    sb = 4'h0;
    wr(3'h1, OFS_PRIO, 8'h10);
    sb = 4'h1;
    rd(3'h1, OFS_PRIO);
    chk(rdv, 32'h0);
    cand <= {(6*NP){3'h5}};
    repeat (2) @(posedge clk);
    #1;
    chk(32'(prio_out[0]), 32'h5);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(3'h1, OFS_MIRROR);
    chk(rdv, 32'h0);
    chk(32'(sniffer_en), 32'h0);
    rd(3'h1, OFS_ACL_CTRL);
    chk(rdv, 32'h60);
    conclude();
  end
endmodule // tb
`default_nettype wire
